// file: design/sync_serial_pkg.sv
// Purpose: Shared constants and types for the timer-channel serial master.
// Assumes: Core clock of 40 MHz; the link clock is the timebase tick.
// Notes: Sequence bit 0 enables data out, sequence bit 1 enables data in.
package sync_serial_pkg;

  // ==========================================================
  // Control codes
  // ==========================================================
  // Service request code that initialises and starts a transfer.
  localparam logic [1:0] SRV_INIT_START = 2'h3;
  // Channel priority code that means the channel is disabled.
  localparam logic [1:0] PRIO_OFF = 2'h0;
  // Function number of the serial function; the value is arbitrary.
  localparam logic [3:0] FUNC_SERIAL = 4'ha;
  // Sequence bit positions.
  localparam int SEQ_TX_BIT = 0;
  localparam int SEQ_RX_BIT = 1;

  // ==========================================================
  // Timing
  // ==========================================================
  // Core clock rate in MHz, for reference by users of the timing below.
  localparam int CORE_CLK_MHZ = 40;
  // Init state budget in core cycles, without and with data out.
  localparam logic [5:0] INIT_CYC_SEQ0 = 6'h1c;
  localparam logic [5:0] INIT_CYC_SEQ1 = 6'h26;
  // Slot transition overhead in core cycles; outside the budget above.
  localparam logic [5:0] SLOT_TRANSITION_TIME = 6'h0e;
  // Shortest legal half period, in timebase ticks.
  localparam logic [15:0] HALF_MIN = 16'h0001;

  // ==========================================================
  // Widths and reset values
  // ==========================================================
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam logic [15:0] WORD_RST = 16'h0000;

  // Transfer setup captured at the end of the init state.
  typedef struct packed {
    logic shift_dir;          // 1 shifts left, msb first.
    logic tx_en;              // Data out line in use.
    logic rx_en;              // Data in line in use.
    logic idle_high;          // Serial clock rests high.
    logic [15:0] half_period; // Timebase ticks per half bit.
    logic [15:0] length;      // Bits to transfer.
    logic [15:0] word;        // Shift word at start.
  } xfer_cfg_t;

endpackage

// file: design/stream_fifo.sv
// Purpose: Small synchronous FIFO with valid and ready on both sides.
// Assumes: One clock; synchronous active-high reset.
// Notes: Full and empty come from a separate occupancy count.
`timescale 1ns/1ps
module stream_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  // Pointer and count widths follow the depth.
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

  // Storage array and pointers.
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [CW-1:0] count_ff;
  logic push;
  logic pop;

  // Handshake flags derive straight from the occupancy.
  assign in_ready = (count_ff != DEPTH_C);
  assign out_valid = (count_ff != '0);
  assign out_data = mem[rd_ptr_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer advance with wrap at the last slot.
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == LAST_C) ? '0 : p + 1'b1;
  endfunction

  // The array is written on every accepted word.
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  // Pointers and count move with push and pop.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= bump(wr_ptr_ff);
      end
      if (pop) begin
        rd_ptr_ff <= bump(rd_ptr_ff);
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule

// file: design/sync_serial_port.sv
// Purpose: Master-only synchronous serial port with clock, out and in.
// Assumes: tick_clk is the timebase; half_period ticks per link clock edge.
// Notes: Received words are queued in a FIFO; a full FIFO holds starts.
//
// Contract
// - Enabled channel starts transfer, interrupts when done.
// - New word plus request runs new transfer.
// - Receive or clock-only restarts by request alone.
// - Init state within 28 or 38 cycles.
// - Bit counter loads full 16-bit length.
// - Clock-only may emit up to FFFF pulses.
// - No realignment; out one end, in other.
// - Data moves one latency after clock edges.
// - Bit rate limited by service time.
// - Out line above clock, in line below.
// - Count bits down, finish and interrupt.
// - Direction zero right lsb, one left msb.
// - Zeros in for transmit-only; still shift.
`timescale 1ns/1ps
module sync_serial_port
  import sync_serial_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic tick_clk,
  input wire logic [1:0] priority_bits,
  input wire logic [3:0] function_select,
  input wire logic [1:0] sequence_bits,
  input wire logic [1:0] service_request_code,
  input wire logic service_request_valid,
  input wire logic [15:0] half_period,
  input wire logic shift_dir,
  input wire logic clk_idle_high,
  input wire logic [15:0] transfer_length,
  input wire logic [15:0] shift_word_wdata,
  input wire logic shift_word_wr,
  output logic [15:0] shift_word,
  output logic busy,
  output logic irq,
  output logic [15:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic sclk_o,
  output logic dout_o,
  output logic dout_oe,
  input wire logic din_i
);
  import sync_serial_pkg::*;

  // ==========================================================
  // Core domain: request, init state and result
  // ==========================================================
  typedef enum logic [1:0] {C_IDLE, C_INIT, C_RUN} core_state_t;

  core_state_t state_ff;          // Core sequencer state.
  logic pending_ff;               // A start request waits.
  logic [5:0] init_cnt_ff;        // Init cycles still to spend.
  logic [5:0] init_age_ff;        // Cycles spent in init, for checks.
  logic [5:0] budget_ff;          // Budget chosen at init entry.
  xfer_cfg_t cfg_ff;              // Setup held for the link side.
  logic [15:0] shift_word_ff;     // Host-visible shift word.
  logic irq_ff;                   // One-cycle completion pulse.
  logic start_tgl_ff;             // Start event toward the link.
  logic done_s1_ff;               // Done toggle synchroniser stages.
  logic done_s2_ff;
  logic done_s3_ff;
  logic done_evt;                 // Transfer finished, core side.
  logic enabled;                  // Channel has a priority and function.
  logic fifo_in_ready;            // Room for the received word.
  logic srv_start;                // Start request seen this cycle.

  // Link-side results read by the core after the done handshake.
  logic [15:0] lword_ff;
  logic done_tgl_ff;

  // Running needs priority and the serial function.
  assign enabled = (priority_bits != PRIO_OFF) &&
                   (function_select == FUNC_SERIAL);
  assign srv_start = service_request_valid &&
                     (service_request_code == SRV_INIT_START);
  assign done_evt = done_s2_ff ^ done_s3_ff;
  assign shift_word = shift_word_ff;
  assign busy = (state_ff != C_IDLE);
  assign irq = irq_ff;

  // The done toggle crosses into the core domain on two flip-flops.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      done_s1_ff <= 1'b0;
      done_s2_ff <= 1'b0;
      done_s3_ff <= 1'b0;
    end else begin
      done_s1_ff <= done_tgl_ff;
      done_s2_ff <= done_s1_ff;
      done_s3_ff <= done_s2_ff;
    end
  end

  // A start request is remembered until the init state takes it.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pending_ff <= 1'b0;
    end else if (srv_start) begin
      // request starts anew
      // A request in the take cycle wins over the clear.
      pending_ff <= 1'b1;
    end else if (state_ff == C_IDLE && enabled && fifo_in_ready) begin
      pending_ff <= 1'b0;
    end
  end

  // Sequencer waits for request and enable, then inits and runs.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= C_IDLE;
      init_cnt_ff <= '0;
      budget_ff <= INIT_CYC_SEQ0;
      start_tgl_ff <= 1'b0;
      cfg_ff <= '0;
    end else begin
      unique case (state_ff)
        C_IDLE: begin
          // Start once enabled with a request pending.
          if (pending_ff && enabled && fifo_in_ready) begin
            state_ff <= C_INIT;
            if (sequence_bits[SEQ_TX_BIT]) begin
              init_cnt_ff <= INIT_CYC_SEQ1 - 1'b1;
              budget_ff <= INIT_CYC_SEQ1;
            end else begin
              init_cnt_ff <= INIT_CYC_SEQ0 - 1'b1;
              budget_ff <= INIT_CYC_SEQ0;
            end
          end
        end
        C_INIT: begin
          // Setup is captured in the last init cycle.
          if (init_cnt_ff == '0) begin
            cfg_ff.shift_dir <= shift_dir;
            cfg_ff.tx_en <= sequence_bits[SEQ_TX_BIT];
            cfg_ff.rx_en <= sequence_bits[SEQ_RX_BIT];
            cfg_ff.idle_high <= clk_idle_high;
            cfg_ff.half_period <= (half_period < HALF_MIN) ?
                                  HALF_MIN : half_period;
            cfg_ff.length <= transfer_length;
            cfg_ff.word <= shift_word_ff;
            start_tgl_ff <= ~start_tgl_ff;
            state_ff <= C_RUN;
          end else begin
            init_cnt_ff <= init_cnt_ff - 1'b1;
          end
        end
        C_RUN: begin
          if (done_evt) begin
            state_ff <= C_IDLE;
          end
        end
        default: begin
          state_ff <= C_IDLE;
        end
      endcase
    end
  end

  // Init age counts the cycles spent in the init state.
  always_ff @(posedge core_clk) begin
    if (rst || state_ff != C_INIT) begin
      init_age_ff <= '0;
    end else begin
      init_age_ff <= init_age_ff + 1'b1;
    end
  end

  // Host writes land only while idle; the result lands at done.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      shift_word_ff <= WORD_RST;
    end else if (done_evt && state_ff == C_RUN) begin
      shift_word_ff <= lword_ff;
    end else if (shift_word_wr && state_ff == C_IDLE) begin
      shift_word_ff <= shift_word_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= done_evt && (state_ff == C_RUN);
    end
  end

  // Received words queue for the host; room was checked at start.
  stream_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) rx_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_data(lword_ff),
    .in_valid(done_evt && state_ff == C_RUN && cfg_ff.rx_en),
    .in_ready(fifo_in_ready),
    .out_data(rx_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
  );

  // ==========================================================
  // Link domain: serial clock, shifting and bit count
  // ==========================================================
  typedef enum logic {L_IDLE, L_RUN} link_state_t;

  link_state_t lstate_ff;         // Link engine state.
  logic lrst_s1_ff;               // Reset synchroniser stages.
  logic lrst_ff;
  logic st_s1_ff;                 // Start toggle synchroniser stages.
  logic st_s2_ff;
  logic st_s3_ff;
  logic din_s1_ff;                // Data in synchroniser stages.
  logic din_s2_ff;
  logic [15:0] half_cnt_ff;       // Ticks into this half period.
  logic [15:0] bits_ff;           // Bits still to clock.
  logic sclk_ff;                  // Serial clock level.
  logic lead_ff;                  // Next edge is the leading edge.
  logic stop_ff;                  // Last trailing edge has gone.
  logic lead_dly_ff;              // One tick after a leading edge.
  logic trail_dly_ff;             // One tick after a trailing edge.
  logic dout_ff;                  // Data out level.
  logic half_done;                // Half period elapsed.
  logic start_evt;                // Start seen on the link side.
  logic in_bit;                   // Bit entering the shift word.

  assign start_evt = st_s2_ff ^ st_s3_ff;
  assign half_done = (lstate_ff == L_RUN) && !stop_ff &&
                     (half_cnt_ff >= cfg_ff.half_period - 1'b1);
  assign in_bit = cfg_ff.rx_en ? din_s2_ff : 1'b0;
  assign sclk_o = sclk_ff;
  assign dout_o = dout_ff;
  // Out line driven only when used
  assign dout_oe = cfg_ff.tx_en;

  // Bit that leaves the shift word for the given direction.
  function automatic logic out_bit(input logic dir,
                                   input logic [15:0] w);
    out_bit = dir ? w[15] : w[0];
  endfunction

  // Reset, start and data in cross on two flip-flops each.
  always_ff @(posedge tick_clk) begin
    lrst_s1_ff <= rst;
    lrst_ff <= lrst_s1_ff;
    st_s1_ff <= start_tgl_ff;
    st_s2_ff <= st_s1_ff;
    st_s3_ff <= st_s2_ff;
    din_s1_ff <= din_i;
    din_s2_ff <= din_s1_ff;
  end

  // Engine toggles the clock each half period of ticks.
  always_ff @(posedge tick_clk) begin
    if (lrst_ff) begin
      lstate_ff <= L_IDLE;
      half_cnt_ff <= '0;
      bits_ff <= '0;
      sclk_ff <= 1'b0;
      lead_ff <= 1'b1;
      stop_ff <= 1'b0;
      lead_dly_ff <= 1'b0;
      trail_dly_ff <= 1'b0;
      done_tgl_ff <= 1'b0;
    end else begin
      lead_dly_ff <= half_done && lead_ff;
      trail_dly_ff <= half_done && !lead_ff;
      unique case (lstate_ff)
        L_IDLE: begin
          sclk_ff <= cfg_ff.idle_high;
          if (start_evt) begin
            bits_ff <= cfg_ff.length;
            half_cnt_ff <= '0;
            lead_ff <= 1'b1;
            stop_ff <= (cfg_ff.length == '0);
            lstate_ff <= L_RUN;
          end
        end
        L_RUN: begin
          if (half_done) begin
            half_cnt_ff <= '0;
            sclk_ff <= ~sclk_ff;
            lead_ff <= ~lead_ff;
            if (!lead_ff) begin
              bits_ff <= bits_ff - 1'b1;
              stop_ff <= (bits_ff == 16'h0001);
            end
          end else if (!stop_ff) begin
            half_cnt_ff <= half_cnt_ff + 1'b1;
          end
          // The transfer ends after the last delayed sample.
          if (stop_ff && !trail_dly_ff) begin
            done_tgl_ff <= ~done_tgl_ff;
            lstate_ff <= L_IDLE;
          end
        end
      endcase
    end
  end

  // Word moves one tick after the edges that own it.
  always_ff @(posedge tick_clk) begin
    if (lrst_ff) begin
      lword_ff <= WORD_RST;
      dout_ff <= 1'b0;
    end else if (lstate_ff == L_IDLE && start_evt) begin
      lword_ff <= cfg_ff.word;
      dout_ff <= out_bit(cfg_ff.shift_dir, cfg_ff.word);
    end else if (trail_dly_ff) begin
      if (cfg_ff.shift_dir) begin
        lword_ff <= {lword_ff[14:0], in_bit};
      end else begin
        lword_ff <= {in_bit, lword_ff[15:1]};
      end
    end else if (lead_dly_ff) begin
      dout_ff <= out_bit(cfg_ff.shift_dir, lword_ff);
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  init_budget_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (state_ff == C_INIT) |-> (init_age_ff < budget_ff))
    else $error("init state overran its budget");

  start_enabled_a: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(state_ff == C_INIT) |-> $past(enabled) && $past(pending_ff))
    else $error("transfer began without enable and request");

  request_taken_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (srv_start && state_ff == C_IDLE && enabled && fifo_in_ready)
      |-> ##[1:2] (state_ff == C_INIT))
    else $error("start request not taken");

  done_irq_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (done_evt && state_ff == C_RUN) |=> irq_ff ##1 !irq_ff)
    else $error("completion gave no single interrupt pulse");

  full_length_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (state_ff == C_INIT && init_cnt_ff == '0)
      |=> cfg_ff.length == $past(transfer_length))
    else $error("length not captured whole");

  count_down_a: assert property (
    @(posedge tick_clk) disable iff (lrst_ff)
    (half_done && !lead_ff) |=> bits_ff == $past(bits_ff) - 16'h0001)
    else $error("bit count did not step down");

  clock_toggle_a: assert property (
    @(posedge tick_clk) disable iff (lrst_ff)
    half_done |=> sclk_ff != $past(sclk_ff))
    else $error("serial clock missed its half period");

  shift_dir_a: assert property (
    @(posedge tick_clk) disable iff (lrst_ff)
    (trail_dly_ff && !cfg_ff.shift_dir)
      |=> lword_ff[14:0] == $past(lword_ff[15:1]))
    else $error("right shift lost alignment");

  zero_fill_a: assert property (
    @(posedge tick_clk) disable iff (lrst_ff)
    (trail_dly_ff && !cfg_ff.rx_en && cfg_ff.shift_dir)
      |=> lword_ff[0] == 1'b0)
    else $error("transmit-only shift did not fill zero");

  cov_tx_done_c: cover property (
    @(posedge core_clk) disable iff (rst)
    irq_ff && cfg_ff.tx_en && !cfg_ff.rx_en);
  cov_duplex_c: cover property (
    @(posedge core_clk) disable iff (rst)
    irq_ff && cfg_ff.tx_en && cfg_ff.rx_en);
  cov_clock_only_c: cover property (
    @(posedge core_clk) disable iff (rst)
    irq_ff && !cfg_ff.tx_en && !cfg_ff.rx_en);
endmodule

// file: testbench/serial_slave_model.sv
// Purpose: Serial slave that returns a fixed word to the master.
// Assumes: The slave changes data on the leading clock edge and inverts it at a frame load.
// Notes: A new frame first shows the inverse of the last bit.
`timescale 1ns/1ps
module serial_slave_model (
  input wire logic sclk,
  input wire logic idle_high,
  input wire logic msb_first,
  input wire logic load,
  input wire logic [15:0] tx_word,
  output logic din
);
  // Index of the next bit to present.
  int idx;
  initial begin
    idx = 0;
    din = 1'b0;
  end
  // A new frame restarts the bit order and inverts the line.
  always @(posedge load) begin
    idx = 0;
    din = ~din;
  end
  // hold past sampling
  // Each bit stays until the next leading edge, a half period after
  // the master samples it. Past 16 bits the line keeps toggling.
  always @(sclk) begin
    if (sclk !== idle_high) begin
      din = (idx > 15) ? ~din : (msb_first ? tx_word[15-idx] : tx_word[idx]);
      idx++;
    end
  end
endmodule

// file: testbench/sync_serial_port_tb.sv
// Purpose: Self-checking bench for the timer-channel serial master.
// Assumes: Core clock 25 ns; tick clock 125 ns with its own phase.
// Notes: Reset is held longer so the tick domain sees it.
`timescale 1ns/1ps
module sync_serial_port_tb;
  import sync_serial_pkg::*;
  // ==========================================
  // Signals
  // ==========================================
  logic core_clk, rst, tick_clk, srv_valid, shift_dir, wr, rx_ready, load;
  logic [1:0] prio, seq, code;
  logic [3:0] func; // Function select driven by the host side.
  logic [15:0] length, wdata, slave_word, shift_word, rx_data;
  logic busy, irq, rx_valid, sclk, dout, dout_oe, din;
  logic [15:0] cap; // Data-out bits seen at trailing edges.
  int nlead; // Leading serial clock edges seen.
  int miscompares, n_compared, cycles;
  // ==========================================
  // Design, slave and clocks
  // ==========================================
  // setup margin kept
  // Two ticks per half bit leave room for the one-tick data delay.
  sync_serial_port u_sync_serial_port (.core_clk(core_clk), .rst(rst),
    .tick_clk(tick_clk), .priority_bits(prio),
    .function_select(func), .sequence_bits(seq),
    .service_request_code(code),
    .service_request_valid(srv_valid), .half_period(16'h0002),
    .shift_dir(shift_dir), .clk_idle_high(1'b0),
    .transfer_length(length), .shift_word_wdata(wdata),
    .shift_word_wr(wr), .shift_word(shift_word), .busy(busy),
    .irq(irq), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .sclk_o(sclk), .dout_o(dout),
    .dout_oe(dout_oe), .din_i(din));
  serial_slave_model u_serial_slave_model (.sclk(sclk), .idle_high(1'b0),
    .msb_first(shift_dir), .load(load), .tx_word(slave_word), .din(din));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    tick_clk = 1'b0;
    #7;
    forever #62.5 tick_clk = ~tick_clk;
  end
  // out after lead
  // Data out moves after the leading edge, so the trailing edge sees it.
  always @(sclk) begin
    if (sclk) nlead++;
    else cap = {cap[14:0], dout};
  end
  // A hang counts as a mismatch and ends the run.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      summarize();
    end
  end
  // ==========================================
  // Tasks
  // ==========================================
  task summarize();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bits expected on the data-out line, first bit ending highest.
  function automatic logic [15:0] exp_out(logic [15:0] w, logic d, int n);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < n; i++) r = {r[14:0], d ? w[15-i] : w[i]};
    return r;
  endfunction
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task put(input logic [15:0] w);
    wdata = w;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
  endtask
  // One service request with the current code; the slave restarts its frame.
  task start();
    cap = 16'h0000;
    nlead = 0;
    cyc(1);
    srv_valid = 1'b1;
    load = 1'b1;
    cyc(1);
    srv_valid = 1'b0;
    load = 1'b0;
  endtask
  // Waits for the completion pulse, then checks word and clock count.
  task done(input logic [15:0] ew, input logic [15:0] en);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 4000) begin
      cyc(1);
      n++;
    end
    if (n >= 4000) miscompares++;
    cyc(1);
    chk(shift_word, ew);
    chk(16'(nlead), en);
    chk({15'h0000, busy}, 16'h0000);
  endtask
  task pop(input logic [15:0] ew);
    chk({15'h0000, rx_valid}, 16'h0001);
    chk(rx_data, ew);
    rx_ready = 1'b1;
    cyc(1);
    rx_ready = 1'b0;
  endtask
  // ==========================================
  // Main sequence
  // ==========================================
  initial begin
    rst = 1'b1;
    {srv_valid, wr, rx_ready, load, shift_dir} = 5'h00;
    prio = PRIO_OFF;
    func = 4'h0;
    code = SRV_INIT_START;
    seq = 2'h3;
    length = 16'h0010;
    wdata = 16'h0000;
    slave_word = 16'h1e87;
    {miscompares, n_compared, cycles, nlead} = {32'h0, 32'h0, 32'h0, 32'h0};
    cap = 16'h0000;
    cyc(20);
    rst = 1'b0;
    cyc(20);
    // Full setup, both lines, lsb first, request held while disabled.
    put(16'ha53c);
    start();
    cyc(10);
    chk({15'h0000, busy}, 16'h0000);
    // Priority alone does not run another function.
    prio = 2'h3;
    cyc(10);
    chk({15'h0000, busy}, 16'h0000);
    prio = PRIO_OFF;
    cyc(1);
    func = FUNC_SERIAL;
    cyc(10);
    chk({15'h0000, busy}, 16'h0000);
    prio = 2'h3;
    done(16'h1e87, 16'h0010);
    chk(cap, exp_out(16'ha53c, 1'b0, 16));
    chk({15'h0000, dout_oe}, 16'h0001);
    pop(16'h1e87);
    // Transmit only, msb first, 8 bits: zeros enter at the low end.
    seq = 2'h1;
    shift_dir = 1'b1;
    length = 16'h0008;
    put(16'h3cf0);
    start();
    done(16'hf000, 16'h0008);
    chk(cap, exp_out(16'h3cf0, 1'b1, 8));
    chk({15'h0000, rx_valid}, 16'h0000);
    // Receive only, restarted by the request alone; other codes wait.
    seq = 2'h2;
    shift_dir = 1'b0;
    slave_word = 16'h005a;
    code = 2'h2;
    start();
    cyc(10);
    chk({15'h0000, busy}, 16'h0000);
    code = SRV_INIT_START;
    start();
    done(16'h5af0, 16'h0008);
    chk({15'h0000, dout_oe}, 16'h0000);
    pop(16'h5af0);
    // Clock only, length above sixteen.
    seq = 2'h0;
    length = 16'h0021;
    start();
    done(16'h0000, 16'h0021);
    // Fill the receive queue until it holds back the next start.
    seq = 2'h2;
    length = 16'h0010;
    slave_word = 16'h1e87;
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      start();
      done(16'h1e87, 16'h0010);
    end
    start();
    cyc(100);
    chk({15'h0000, busy}, 16'h0000);
    pop(16'h1e87);
    done(16'h1e87, 16'h0010);
    for (int i = 0; i < FIFO_DEPTH; i++) pop(16'h1e87);
    chk({15'h0000, rx_valid}, 16'h0000);
    summarize();
  end
endmodule
